// ===== cbs_pkg.sv
// Purpose: Shared constants and types of the charge-balance converter sequencer
// Assumes: Control clock mclk at 10 MHz
// Notes:   Times kept in their own units, cycle counts derived from them
`default_nettype none
package cbs_pkg;

    // ==========================================================
    // Clock and timing
    localparam int CLK_HZ         = 10_000_000;
    localparam int STARTUP_NS     = 10_000;
    localparam int SHUTDOWN_NS    = 10_000;
    localparam int INVALID_NS     = 5_000;
    localparam int IDLE_GAP_NS    = 2_500;
    localparam int CONV_TYP_MS    = 10;
    localparam int CONV_MAX_MS    = 12;
    localparam int MIN_RATE_HZ    = 84;
    localparam int TYP_RATE_HZ    = 100;
    localparam int NS_PER_S       = 1_000_000_000;
    localparam int CLK_NS         = NS_PER_S / CLK_HZ;
    // Least times round up
    localparam int STARTUP_CYC    = (STARTUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int SHUTDOWN_CYC   = (SHUTDOWN_NS + CLK_NS - 1) / CLK_NS;
    localparam int INVALID_CYC    = (INVALID_NS + CLK_NS - 1) / CLK_NS;
    // Idle gap is "about": round down, at least one cycle
    localparam int IDLE_GAP_CYC   = (IDLE_GAP_NS / CLK_NS) < 1 ? 1 : (IDLE_GAP_NS / CLK_NS);
    // Whole cycle kept to the typical rate; integration takes the rest
    localparam int PERIOD_CYC     = CLK_HZ / TYP_RATE_HZ;
    localparam int INTEG_CYC      = PERIOD_CYC - STARTUP_CYC - SHUTDOWN_CYC - IDLE_GAP_CYC;
    localparam int CONV_MAX_CYC   = (CLK_HZ / 1000) * CONV_MAX_MS;

    // ==========================================================
    // Result format
    localparam int MAX_COUNT      = 1999;
    localparam int PHASE_W        = 20;

    // ==========================================================
    // Types
    typedef enum {
        CBS_IDLE,
        CBS_STARTUP,
        CBS_CONVERT,
        CBS_SHUTDOWN,
        CBS_GAP
    } cbs_phase_t;

    typedef struct packed {
        logic       thousands;
        logic [3:0] hundreds;
        logic [3:0] tens;
        logic [3:0] ones;
    } cbs_bcd_t;

    typedef struct packed {
        logic busy;
        logic data_valid;
        logic ref_pulse;
        logic integ_reset;
    } cbs_status_t;

endpackage
`default_nettype wire

// ===== cbs_bcd_digit.sv
// Purpose: One decade of the BCD data counter
// Assumes: Clear and increment never asserted to mean both at once
// Notes:   Carry out is combinational so a chain steps in one clock
`timescale 1ns/1ps
`default_nettype none
module cbs_bcd_digit (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst,
    // Control
    input  wire logic       clear,
    input  wire logic       inc,
    // Digit
    output logic [3:0] digit,
    output logic       carry
);
    typedef struct packed {
        logic [3:0] digit;
    } cbs_dig_state_t;

    cbs_dig_state_t state;
    cbs_dig_state_t next_state;

    // ==========================================================
    // Next value
    always_comb begin
        next_state = state;
        if (clear) begin
            next_state.digit = 4'h0;
        end else if (inc) begin
            next_state.digit = (state.digit == 4'h9) ? 4'h0 : state.digit + 4'h1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign digit = state.digit;
    assign carry = inc && (state.digit == 4'h9);
endmodule
`default_nettype wire

// ===== cbs_sequencer.sv
// Purpose: Start-up, counting and shutdown sequencer of a 3-1/2 digit
//          charge-balance converter with latched BCD result
// Assumes: Analog integrator outside; comparator gives one decision bit
// Notes:   Free-run period set by the clock counter terminal count
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Start strobe while idle raises busy on the third clock after start, begins 10 us start-up
// - Start-up discharges integrator and clears both counters
// - Conversion ends at clock terminal count or data overflow, first wins
// - Clock counter counts after reset pulse, pulses end-of-conversion at terminal
// - Data counter cleared with clock counter, counts each reference pulse
// - Reference pulse lasts one clock, issued only when comparator asks
// - End-of-conversion stops both counters and starts 10 us shutdown
// - Result-valid low 5 us inside shutdown while latches load
// - Final BCD count loaded into output latches, maximum 1999
// - Latched data hold until result-valid falls on a later conversion
// - Start input ignored while busy
// - Started conversion always runs to completion, nothing aborts it
// - Start held high converts continuously, at least 84 per second
// - One conversion takes typically 10 ms, at most 12 ms
// - Busy fall means result latched, busy rise means new conversion
// - Free-running holds busy low about 2.5 us between conversions
module cbs_sequencer #(
    parameter int INTEG_CYC    = cbs_pkg::INTEG_CYC,
    parameter int STARTUP_CYC  = cbs_pkg::STARTUP_CYC,
    parameter int SHUTDOWN_CYC = cbs_pkg::SHUTDOWN_CYC,
    parameter int INVALID_CYC  = cbs_pkg::INVALID_CYC,
    parameter int GAP_CYC      = cbs_pkg::IDLE_GAP_CYC
) (
    // Clock and reset
    input  wire logic            mclk,
    input  wire logic            rst,
    // Host control
    input  wire logic            start_conv,
    // Comparator decision
    input  wire logic            comp_high,
    // Status and analog switches
    output cbs_pkg::cbs_status_t status,
    // Latched result
    output cbs_pkg::cbs_bcd_t    digits
);
    localparam int CW = cbs_pkg::PHASE_W;

    // ==========================================================
    // Elaboration checks
    // Timer and clock counter are CW bits; a longer span would wrap early
    if (INTEG_CYC < 1 || INTEG_CYC >= (1 << CW)) begin : gen_bad_integ
        $error("cbs_sequencer: integration count out of range");
    end
    if (STARTUP_CYC < 1 || STARTUP_CYC >= (1 << CW)) begin : gen_bad_startup
        $error("cbs_sequencer: start-up count out of range");
    end
    // Latch loads one cycle before the end, after valid has dropped
    if (INVALID_CYC < 2 || SHUTDOWN_CYC <= INVALID_CYC ||
        SHUTDOWN_CYC >= (1 << CW)) begin : gen_bad_shutdown
        $error("cbs_sequencer: shutdown counts out of range");
    end
    if (GAP_CYC < 1 || GAP_CYC >= (1 << CW)) begin : gen_bad_gap
        $error("cbs_sequencer: gap count out of range");
    end
    // Whole conversion must stay inside the longest allowed time
    if (STARTUP_CYC + INTEG_CYC + SHUTDOWN_CYC > cbs_pkg::CONV_MAX_CYC) begin : gen_bad_total
        $error("cbs_sequencer: conversion longer than allowed");
    end

    typedef struct packed {
        logic [1:0]          start_sync;
        logic                thousands;
        logic                comp_sync0;
        logic                comp_sync1;
        cbs_pkg::cbs_phase_t phase;
        logic [CW-1:0]       timer;
        logic [CW-1:0]       clk_cnt;
        logic                overflow;
        logic                ref_pulse;
        logic                busy;
        logic                data_valid;
        logic                integ_reset;
        cbs_pkg::cbs_bcd_t   latch;
    } cbs_state_t;

    cbs_state_t state;
    cbs_state_t next_state;

    // ==========================================================
    // Data counter, three decades plus a thousands bit
    logic       cnt_clear;
    logic       cnt_inc;
    logic [3:0] dig [3];
    logic [2:0] carry;
    logic       top_full;
    logic       thousands;
    logic       next_thousands;

    assign cnt_clear = (state.phase == cbs_pkg::CBS_STARTUP);
    // Reference pulse counted only in the conversion window
    assign cnt_inc = state.ref_pulse && (state.phase == cbs_pkg::CBS_CONVERT) &&
                     !state.overflow;

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gen_dec
            cbs_bcd_digit u_dig (
                .mclk  (mclk),
                .rst   (rst),
                .clear (cnt_clear),
                .inc   ((g == 0) ? cnt_inc : carry[(g == 0) ? 0 : g - 1]),
                .digit (dig[g]),
                .carry (carry[g])
            );
        end
    endgenerate

    // Overflow past 1999 ends the conversion instead of wrapping
    assign top_full = thousands && carry[2];
    assign next_thousands = cnt_clear ? 1'b0 : (carry[2] ? 1'b1 : thousands);
    // Held in the state record; frozen once full so overflow saturates
    assign thousands = state.thousands;

    // ==========================================================
    // Sequencer
    logic start_lvl;
    logic strobe;
    logic eoc;

    assign start_lvl = state.start_sync[1];
    // Level, not edge, so a start tied high free-runs
    assign strobe = start_lvl;
    assign eoc = (state.phase == cbs_pkg::CBS_CONVERT) &&
                 ((state.clk_cnt == CW'(INTEG_CYC - 1)) || state.overflow);

    always_comb begin
        next_state = state;
        next_state.start_sync = {state.start_sync[0], start_conv};
        next_state.thousands = top_full ? state.thousands : next_thousands;
        next_state.comp_sync0 = comp_high;
        next_state.comp_sync1 = state.comp_sync0;
        next_state.ref_pulse = 1'b0;
        next_state.timer = state.timer + CW'(1);
        case (state.phase)
            cbs_pkg::CBS_IDLE: begin
                next_state.timer = '0;
                if (strobe) begin
                    next_state.phase = cbs_pkg::CBS_STARTUP;
                end
            end
            cbs_pkg::CBS_STARTUP: begin
                next_state.clk_cnt = '0;
                next_state.overflow = 1'b0;
                if (state.timer == CW'(STARTUP_CYC - 1)) begin
                    next_state.phase = cbs_pkg::CBS_CONVERT;
                    next_state.timer = '0;
                end
            end
            cbs_pkg::CBS_CONVERT: begin
                next_state.clk_cnt = state.clk_cnt + CW'(1);
                // One-clock pulse, only when the summing node asks
                next_state.ref_pulse = state.comp_sync1 && !eoc;
                if (top_full) begin
                    next_state.overflow = 1'b1;
                end
                if (eoc) begin
                    next_state.phase = cbs_pkg::CBS_SHUTDOWN;
                    next_state.timer = '0;
                end
            end
            cbs_pkg::CBS_SHUTDOWN: begin
                // Valid drops for the last stretch of shutdown
                if (state.timer == CW'(SHUTDOWN_CYC - INVALID_CYC - 1)) begin
                    next_state.data_valid = 1'b0;
                end
                if (state.timer == CW'(SHUTDOWN_CYC - 2)) begin
                    // Saturate at full scale on overflow
                    next_state.latch = state.overflow ? cbs_pkg::cbs_bcd_t'(13'h1999) :
                        cbs_pkg::cbs_bcd_t'({thousands, dig[2], dig[1], dig[0]});
                end
                if (state.timer == CW'(SHUTDOWN_CYC - 1)) begin
                    next_state.data_valid = 1'b1;
                    next_state.phase = cbs_pkg::CBS_GAP;
                    next_state.timer = '0;
                end
            end
            cbs_pkg::CBS_GAP: begin
                // Start refused here too, so strobed and free-run share the gap
                if (state.timer == CW'(GAP_CYC - 1)) begin
                    next_state.phase = cbs_pkg::CBS_IDLE;
                end
            end
            default: begin
                next_state.phase = cbs_pkg::CBS_IDLE;
            end
        endcase
        // Busy follows phase; start ignored outside idle
        next_state.busy = (next_state.phase == cbs_pkg::CBS_STARTUP) ||
                          (next_state.phase == cbs_pkg::CBS_CONVERT) ||
                          (next_state.phase == cbs_pkg::CBS_SHUTDOWN);
        // Discharge switch registered with phase, no decode glitch at the pin
        next_state.integ_reset = (next_state.phase == cbs_pkg::CBS_STARTUP);
    end

    // Valid starts low: no result exists until the first conversion ends
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= '{phase: cbs_pkg::CBS_IDLE, data_valid: 1'b0, default: '0};
        end else begin
            state <= next_state;
        end
    end

    // ==========================================================
    // Outputs; cycle length fixed by counts
    assign status.busy        = state.busy;
    assign status.data_valid  = state.data_valid;
    assign status.ref_pulse   = state.ref_pulse;
    assign status.integ_reset = state.integ_reset;
    assign digits             = state.latch;
endmodule
`default_nettype wire

// ===== cbs_sequencer_checker.sv
// Purpose: Port assertions for the sequencer
// Assumes: Counts match the bound instance
// Notes:   Counters replace long repetitions
`timescale 1ns/1ps
`default_nettype none
module cbs_sequencer_checker #(
    parameter int STARTUP_CYC = 100,
    parameter int INVALID_CYC = 50
) (
    // Clock and reset
    input wire logic                 mclk,
    input wire logic                 rst,
    // Watched ports
    input wire logic                 comp_high,
    input wire cbs_pkg::cbs_status_t status,
    input wire cbs_pkg::cbs_bcd_t    digits
);
    int   su_n;
    int   lo_n;
    logic seen;
    // Span counters; the first result after reset has no invalid span to time
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            su_n <= 0;
            lo_n <= 0;
            seen <= 1'b0;
        end else begin
            su_n <= status.integ_reset ? su_n + 1 : 0;
            lo_n <= (status.data_valid || !status.busy) ? 0 : lo_n + 1;
            seen <= seen | status.data_valid;
        end
    end
    // ==========================================================
    // Assertions
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    chk_start_disch: assert property ($rose(status.busy) |-> status.integ_reset)
        else $error("no discharge at start");
    chk_startup_len: assert property ($fell(status.integ_reset) |-> su_n == STARTUP_CYC)
        else $error("start-up length wrong");
    chk_ref_quiet: assert property (status.integ_reset |-> !status.ref_pulse)
        else $error("reference pulse in start-up");
    chk_ref_cause: assert property (status.ref_pulse |-> $past(comp_high, 3))
        else $error("reference pulse unasked");
    chk_inval_len: assert property ($rose(status.data_valid) && seen |-> lo_n == INVALID_CYC)
        else $error("invalid span length wrong");
    chk_inval_busy: assert property ($fell(status.data_valid) |-> status.busy)
        else $error("result invalid while idle");
    chk_digits_hold: assert property (status.data_valid |=> $stable(digits))
        else $error("digits changed while valid");
    chk_done_valid: assert property ($fell(status.busy) |-> status.data_valid)
        else $error("busy fell before result valid");
    cover property ($fell(status.busy));
    cover property ($rose(status.data_valid) && seen);
    cover property (status.ref_pulse);
endmodule
bind cbs_sequencer cbs_sequencer_checker #(
    .STARTUP_CYC(STARTUP_CYC), .INVALID_CYC(INVALID_CYC)
) u_chk (.mclk(mclk), .rst(rst), .comp_high(comp_high), .status(status), .digits(digits));
`default_nettype wire

// ===== cbs_host_model.sv
// Purpose: Host and comparator model at the far side
// Assumes: Bench commands change just after the clock edge
// Notes:   Strobes last six clocks, above the minimum width
`timescale 1ns/1ps
`default_nettype none
module cbs_host_model (
    // Clock
    input  wire logic       mclk,
    // Bench commands
    input  wire logic       req,
    input  wire logic       free_run,
    input  wire logic [1:0] comp_mode,
    // Block inputs
    output logic            start_conv,
    output logic            comp_high
);
    logic [2:0] hold = 3'h0;
    logic       req_d = 1'b0;
    logic       comp = 1'b0;
    always @(posedge mclk) begin
        req_d <= req;
        hold  <= (req && !req_d) ? 3'h6 : hold - 3'(hold != 3'h0);
        // Mode 2 alternates each clock so the count is half the window
        comp  <= (comp_mode == 2'h1) || (comp_mode == 2'h2 && !comp);
    end
    assign start_conv = free_run || hold != 3'h0;
    assign comp_high  = comp;
endmodule
`default_nettype wire

// ===== cbs_sequencer_bench.sv
// Purpose: Self-checking bench for the sequencer
// Assumes: Integration window cut to 2101 clocks, 2100 comparator decisions
// Notes:   A steady comparator overflows within that window
`timescale 1ns/1ps
`default_nettype none
module cbs_sequencer_bench;
    // Even count of decisions, so an alternating comparator gives half whatever its phase
    localparam int INTEG = 2101;
    localparam int FULL  = cbs_pkg::STARTUP_CYC + INTEG + cbs_pkg::SHUTDOWN_CYC;
    localparam int GAP   = cbs_pkg::IDLE_GAP_CYC;
    logic                 mclk = 1'b0;
    logic                 rst = 1'b1;
    logic                 req = 1'b0;
    logic                 free_run = 1'b0;
    logic [1:0]           comp_mode = 2'h0;
    wire logic            start_conv;
    wire logic            comp_high;
    cbs_pkg::cbs_status_t status;
    cbs_pkg::cbs_bcd_t    digits;
    int                   err_count = 0;
    int                   checks_done = 0;
    int                   n;
    always #50 mclk = ~mclk;
    cbs_sequencer #(.INTEG_CYC(INTEG)) dut (.mclk(mclk), .rst(rst), .start_conv(start_conv),
        .comp_high(comp_high), .status(status), .digits(digits));
    cbs_host_model host (.mclk(mclk), .req(req), .free_run(free_run), .comp_mode(comp_mode),
        .start_conv(start_conv), .comp_high(comp_high));
    task automatic check(input logic [12:0] got, input logic [12:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Counts clocks until busy equals lvl; a late strobe lands mid-conversion
    task automatic wait_busy(input logic lvl, input int lim);
        n = 0;
        while (status.busy !== lvl && n < lim) begin
            @(posedge mclk) #1;
            n++;
            req = (n >= 500 && n < 520) ? 1'b1 : 1'b0;
        end
        check(13'(n < lim), 13'h1);
    endtask
    task automatic t_conv(input logic [1:0] mode, input logic [12:0] exp, input logic full);
        comp_mode = mode;
        req = 1'b1;
        wait_busy(1'b1, 6);
        wait_busy(1'b0, FULL + 5);
        if (full) check(13'(n), 13'(FULL));
        else check(13'(n < FULL), 13'h1);
        check(digits, exp);
        repeat (40) @(posedge mclk) #1;
        check({9'h0, status}, 13'h4);
        check(digits, exp);
    endtask
    task automatic t_free;
        comp_mode = 2'h0;
        free_run = 1'b1;
        wait_busy(1'b1, 6);
        wait_busy(1'b0, FULL + 5);
        check(digits, 13'h0);
        wait_busy(1'b1, 60);
        check(13'(n >= GAP && n <= GAP + 5), 13'h1);
        free_run = 1'b0;
        wait_busy(1'b0, FULL + 5);
        check(13'(n), 13'(FULL));
    endtask
    initial begin
        repeat (3) @(posedge mclk) #1;
        check({9'h0, status}, 13'h0);
        check(digits, 13'h0);
        rst = 1'b0;
        t_conv(2'h0, 13'h0, 1'b1);
        t_conv(2'h2, 13'h1050, 1'b1);
        t_conv(2'h1, 13'h1999, 1'b0);
        t_free();
        final_report();
    end
    initial begin
        #(FULL * 8 * 100);
        err_count++;
        final_report();
    end
endmodule
`default_nettype wire
